// File: rtl/bhrp_device_end.sv
// Device end of the byte host port: register file, packet FIFOs, irq.
// Host pins are asynchronous to CLK_IN and pass two flops first.
// FIFO_DEPTH must be a power of two.
`timescale 1ns/1ns
module bhrp_device_end
  import bhrp_pkg::*;
#(
  parameter int REG_DEPTH = BHRP_REG_DEPTH,
  parameter int FIFO_DEPTH = BHRP_FIFO_DEPTH
) (
  // Clock and resets
  input wire logic CLK_IN,
  input wire logic RESET_IN,
  input wire logic MASTER_RESET_N_IN,
  // Host pins
  bhrp_if.device HOST_PORT,
  // Core events
  input wire logic IRQ_PENDING_IN,
  // Packets toward the link
  output logic [7:0] LINK_TX_DATA_OUT,
  output logic LINK_TX_VALID_OUT,
  input wire logic LINK_TX_READY_IN,
  // Packets from the link
  input wire logic [7:0] LINK_RX_DATA_IN,
  input wire logic LINK_RX_VALID_IN,
  output logic LINK_RX_READY_OUT,
  // Core view of the register file
  input wire logic [8:0] CORE_ADDR_IN,
  output logic [7:0] CORE_DATA_OUT
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  localparam int PTR_W = (FIFO_DEPTH > 1) ? $clog2(FIFO_DEPTH) : 1;
  localparam logic [PTR_W:0] FIFO_FULL = (PTR_W + 1)'(FIFO_DEPTH);

  typedef struct packed {
    bhrp_pins_t s1;
    bhrp_pins_t s2;
    logic rd_act;
    logic wr_act;
    logic [8:0] rd_addr;
    logic [8:0] wr_addr;
    logic [7:0] wr_data;
    logic [7:0] dout;
    logic doe;
    logic irq;
    logic [FIFO_DEPTH-1:0][7:0] tx_mem;
    logic [FIFO_DEPTH-1:0][7:0] rx_mem;
    logic [PTR_W-1:0] tx_wp;
    logic [PTR_W-1:0] tx_rp;
    logic [PTR_W-1:0] rx_wp;
    logic [PTR_W-1:0] rx_rp;
    logic [PTR_W:0] tx_cnt;
    logic [PTR_W:0] rx_cnt;
    logic [7:0] core_data;
    logic [REG_DEPTH-1:0][7:0] regs;
  } bhrp_dev_state_t;

  localparam bhrp_dev_state_t DEV_RESET = '{
    s1: BHRP_PINS_IDLE,
    s2: BHRP_PINS_IDLE,
    regs: {REG_DEPTH{BHRP_REG_RESET}},
    default: '0
  };

  bhrp_dev_state_t st_reg;
  bhrp_dev_state_t st_next;
  bhrp_pins_t pins_now;

  // Raw pins gathered for the synchroniser
  assign pins_now = '{cs_n: HOST_PORT.host_select_n,
                      rd_n: HOST_PORT.host_read_strobe_n,
                      wr_n: HOST_PORT.host_write_strobe_n,
                      addr: HOST_PORT.host_addr_lines,
                      data: HOST_PORT.host_data_lines};

  // ---------------------------------------------------------------
  // Next-state logic
  // ---------------------------------------------------------------
  // Decode, register access, FIFO moves
  always_comb begin
    logic rd_now;
    logic wr_now;
    logic rd_end;
    logic wr_end;
    logic tx_push;
    logic tx_pop;
    logic rx_push;
    logic rx_pop;
    logic [7:0] rd_byte;
    rd_now = 1'b0;
    wr_now = 1'b0;
    rd_end = 1'b0;
    wr_end = 1'b0;
    tx_push = 1'b0;
    tx_pop = 1'b0;
    rx_push = 1'b0;
    rx_pop = 1'b0;
    rd_byte = 8'h00;
    st_next = st_reg;
    // Two flops on every host pin before anything looks at them
    st_next.s1 = pins_now;
    st_next.s2 = st_reg.s1;

    // RULE6 select gates strobes
    // RULE4 both low writes
    wr_now = !st_reg.s2.cs_n && !st_reg.s2.wr_n;
    // RULE5 read needs write high
    rd_now = !st_reg.s2.cs_n && !st_reg.s2.rd_n && st_reg.s2.wr_n;
    st_next.wr_act = wr_now;
    st_next.rd_act = rd_now;

    // Data is taken late in the strobe, where a slow host has it stable
    if (wr_now) begin
      st_next.wr_addr = st_reg.s2.addr;
      st_next.wr_data = st_reg.s2.data;
    end
    if (rd_now) begin
      st_next.rd_addr = st_reg.s2.addr;
    end
    wr_end = st_reg.wr_act && !wr_now;
    rd_end = st_reg.rd_act && !rd_now;

    // RULE1 nine-bit address decode
    if (st_reg.s2.addr == BHRP_FIFO_PORT_ADDR) begin
      rd_byte = (st_reg.rx_cnt != '0) ? st_reg.rx_mem[st_reg.rx_rp] : 8'h00;
    end else if (st_reg.s2.addr == BHRP_FIFO_STAT_ADDR) begin
      rd_byte[BHRP_STAT_RX_EMPTY_BIT] = (st_reg.rx_cnt == '0);
      rd_byte[BHRP_STAT_TX_FULL_BIT] = (st_reg.tx_cnt == FIFO_FULL);
      rd_byte[BHRP_STAT_IRQ_BIT] = st_reg.irq;
    end else if (int'(st_reg.s2.addr) < REG_DEPTH) begin
      rd_byte = st_reg.regs[st_reg.s2.addr];
    end

    // RULE2 device drives only reads
    // RULE11 bus released otherwise
    st_next.doe = rd_now;
    st_next.dout = rd_now ? rd_byte : 8'h00;

    // RULE3 store on write end
    // RULE10 FIFO behind same port
    if (wr_end) begin
      if (st_reg.wr_addr == BHRP_FIFO_PORT_ADDR) begin
        tx_push = (st_reg.tx_cnt != FIFO_FULL);
      end else if (st_reg.wr_addr != BHRP_FIFO_STAT_ADDR &&
                   int'(st_reg.wr_addr) < REG_DEPTH) begin
        st_next.regs[st_reg.wr_addr] = st_reg.wr_data;
      end
    end

    // RULE10 pop after FIFO read
    rx_pop = rd_end && (st_reg.rd_addr == BHRP_FIFO_PORT_ADDR) &&
             (st_reg.rx_cnt != '0);
    rx_push = LINK_RX_VALID_IN && (st_reg.rx_cnt != FIFO_FULL);
    tx_pop = LINK_TX_READY_IN && (st_reg.tx_cnt != '0);

    // Host-to-link queue
    if (tx_push) begin
      st_next.tx_mem[st_reg.tx_wp] = st_reg.wr_data;
      st_next.tx_wp = st_reg.tx_wp + 1'b1;
    end
    if (tx_pop) begin
      st_next.tx_rp = st_reg.tx_rp + 1'b1;
    end
    if (tx_push && !tx_pop) begin
      st_next.tx_cnt = st_reg.tx_cnt + 1'b1;
    end else if (!tx_push && tx_pop) begin
      st_next.tx_cnt = st_reg.tx_cnt - 1'b1;
    end

    // Link-to-host queue
    if (rx_push) begin
      st_next.rx_mem[st_reg.rx_wp] = LINK_RX_DATA_IN;
      st_next.rx_wp = st_reg.rx_wp + 1'b1;
    end
    if (rx_pop) begin
      st_next.rx_rp = st_reg.rx_rp + 1'b1;
    end
    if (rx_push && !rx_pop) begin
      st_next.rx_cnt = st_reg.rx_cnt + 1'b1;
    end else if (!rx_push && rx_pop) begin
      st_next.rx_cnt = st_reg.rx_cnt - 1'b1;
    end

    // RULE7 pending event pulls line
    st_next.irq = IRQ_PENDING_IN;

    // Core read port, out of range reads zero
    st_next.core_data = (int'(CORE_ADDR_IN) < REG_DEPTH) ?
                        st_reg.regs[CORE_ADDR_IN] : 8'h00;

    if (RESET_IN) begin
      st_next = DEV_RESET;
    end
  end

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------
  // RULE9 asynchronous master reset
  always_ff @(posedge CLK_IN or negedge MASTER_RESET_N_IN) begin
    if (!MASTER_RESET_N_IN) begin
      st_reg <= DEV_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  // Pin side, all from flops
  assign HOST_PORT.dev_data_out = st_reg.dout;
  assign HOST_PORT.dev_data_oe = st_reg.doe;
  // RULE8 enable only, never high
  assign HOST_PORT.irq_oe = st_reg.irq;

  // Link and core side
  assign LINK_TX_DATA_OUT = st_reg.tx_mem[st_reg.tx_rp];
  assign LINK_TX_VALID_OUT = (st_reg.tx_cnt != '0);
  assign LINK_RX_READY_OUT = (st_reg.rx_cnt != FIFO_FULL);
  assign CORE_DATA_OUT = st_reg.core_data;

endmodule : bhrp_device_end

// File: rtl/bhrp_host_end.sv
// Host end of the byte port: turns one request into a strobed bus cycle.
// Assumes the device samples pins through two flops on the same clock.
`timescale 1ns/1ns
module bhrp_host_end
  import bhrp_pkg::*;
#(
  parameter bit COMBINED_RW = 1'b0,
  parameter int SETUP_CYCLES = BHRP_SETUP_CYCLES,
  parameter int STROBE_CYCLES = BHRP_STROBE_CYCLES,
  parameter int HOLD_CYCLES = BHRP_HOLD_CYCLES
) (
  // Clock and reset
  input wire logic CLK_IN,
  input wire logic RESET_IN,
  // Pins
  bhrp_if.host HOST_PORT,
  // Requests
  input wire logic REQ_VALID_IN,
  input wire logic REQ_WRITE_IN,
  input wire logic [8:0] REQ_ADDR_IN,
  input wire logic [7:0] REQ_DATA_IN,
  output logic REQ_READY_OUT,
  // Answers
  output logic RSP_VALID_OUT,
  output logic [7:0] RSP_DATA_OUT,
  output logic IRQ_OUT
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    bhrp_host_state_t state;
    logic [7:0] cnt;
    logic write;
    logic [8:0] addr;
    logic [7:0] dout;
    logic doe;
    logic cs_n;
    logic rd_n;
    logic wr_n;
    logic rsp_valid;
    logic [7:0] rsp_data;
    logic [7:0] d_s1;
    logic [7:0] d_s2;
    logic irq_s1;
    logic irq_s2;
  } bhrp_host_st_t;

  localparam bhrp_host_st_t HOST_RESET = '{state: BHRP_IDLE, cs_n: 1'b1,
    rd_n: !COMBINED_RW, wr_n: 1'b1, irq_s1: 1'b1, irq_s2: 1'b1,
    default: '0};

  bhrp_host_st_t st_reg;
  bhrp_host_st_t st_next;

  // ---------------------------------------------------------------
  // Next-state logic
  // ---------------------------------------------------------------
  // Cycle sequencer: setup, strobe, hold
  always_comb begin
    st_next = st_reg;
    st_next.rsp_valid = 1'b0;
    st_next.d_s1 = HOST_PORT.host_data_lines;
    st_next.d_s2 = st_reg.d_s1;
    st_next.irq_s1 = HOST_PORT.host_irq_n;
    st_next.irq_s2 = st_reg.irq_s1;
    unique case (st_reg.state)
      BHRP_IDLE: begin
        if (REQ_VALID_IN) begin
          // RULE6 select opens access
          // RULE1 address held whole cycle
          st_next.cs_n = 1'b0;
          st_next.addr = REQ_ADDR_IN;
          st_next.write = REQ_WRITE_IN;
          st_next.dout = REQ_DATA_IN;
          // RULE2 host drives writes only
          st_next.doe = REQ_WRITE_IN;
          // RULE4 direction held all cycle
          // Read low with write high would be a read, so set it up front
          if (COMBINED_RW) begin
            st_next.wr_n = !REQ_WRITE_IN;
          end
          st_next.cnt = 8'(SETUP_CYCLES - 1);
          st_next.state = BHRP_SETUP;
        end
      end
      BHRP_SETUP: begin
        if (st_reg.cnt == 8'h00) begin
          // RULE4 combined line keeps read low
          st_next.wr_n = !st_reg.write;
          st_next.rd_n = COMBINED_RW ? 1'b0 : st_reg.write;
          st_next.cnt = 8'(STROBE_CYCLES - 1);
          st_next.state = BHRP_STROBE;
        end else begin
          st_next.cnt = st_reg.cnt - 8'h01;
        end
      end
      BHRP_STROBE: begin
        if (st_reg.cnt == 8'h00) begin
          // Late sample covers the device's sync delay
          st_next.rsp_valid = !st_reg.write;
          st_next.rsp_data = st_reg.write ? st_reg.rsp_data : st_reg.d_s2;
          // Combined line stays put; a stray read in hold would pop the FIFO
          st_next.wr_n = COMBINED_RW ? st_reg.wr_n : 1'b1;
          st_next.rd_n = !COMBINED_RW;
          st_next.cnt = 8'(HOLD_CYCLES - 1);
          st_next.state = BHRP_HOLD;
        end else begin
          st_next.cnt = st_reg.cnt - 8'h01;
        end
      end
      BHRP_HOLD: begin
        if (st_reg.cnt == 8'h00) begin
          st_next.cs_n = 1'b1;
          st_next.wr_n = 1'b1;
          st_next.doe = 1'b0;
          st_next.state = BHRP_IDLE;
        end else begin
          st_next.cnt = st_reg.cnt - 8'h01;
        end
      end
    endcase
    if (RESET_IN) begin
      st_next = HOST_RESET;
    end
  end

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------
  always_ff @(posedge CLK_IN) begin
    st_reg <= st_next;
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign HOST_PORT.host_addr_lines = st_reg.addr;
  assign HOST_PORT.host_select_n = st_reg.cs_n;
  assign HOST_PORT.host_read_strobe_n = st_reg.rd_n;
  assign HOST_PORT.host_write_strobe_n = st_reg.wr_n;
  assign HOST_PORT.host_data_out = st_reg.dout;
  assign HOST_PORT.host_data_oe = st_reg.doe;
  assign REQ_READY_OUT = (st_reg.state == BHRP_IDLE) && !RESET_IN;
  assign RSP_VALID_OUT = st_reg.rsp_valid;
  assign RSP_DATA_OUT = st_reg.rsp_data;
  // RULE7 low line means pending
  assign IRQ_OUT = !st_reg.irq_s2;

endmodule : bhrp_host_end

// File: rtl/bhrp_if.sv
// Pin bundle between host end and device end of the byte port.
// Resolves the shared data bus and the open-drain interrupt line here,
// modelling the pull-ups; the modules only see enables and levels.
`timescale 1ns/1ns
interface bhrp_if;
  import bhrp_pkg::*;

  logic [8:0] host_addr_lines;
  logic host_select_n;
  logic host_read_strobe_n;
  logic host_write_strobe_n;
  logic [7:0] host_data_out;
  logic host_data_oe;
  logic [7:0] dev_data_out;
  logic dev_data_oe;
  logic irq_oe;
  logic [7:0] host_data_lines;
  logic host_irq_n;

  // Wire level of the shared bus, pull-ups when nobody drives
  assign host_data_lines = dev_data_oe ? dev_data_out :
                           (host_data_oe ? host_data_out : BHRP_BUS_IDLE);
  assign host_irq_n = ~irq_oe;

  modport device (
    input host_addr_lines, host_select_n, host_read_strobe_n,
    input host_write_strobe_n, host_data_lines,
    output dev_data_out, dev_data_oe, irq_oe
  );

  modport host (
    output host_addr_lines, host_select_n, host_read_strobe_n,
    output host_write_strobe_n, host_data_out, host_data_oe,
    input host_data_lines, host_irq_n
  );

endinterface : bhrp_if

// File: rtl/bhrp_pkg.sv
// Shared constants and types for the byte host register port, both ends.
// Assumes both ends run on one CLK_IN and meet through bhrp_if.
//
// Overview of operation
// RULE1 - Nine-bit address picks one internal byte
// RULE2 - Eight-bit two-way data, device drives reads
// RULE3 - Select plus write strobe stores bus byte
// RULE4 - Both strobes low means a write
// RULE5 - Select, read low, write high reads
// RULE6 - Strobes ignored while select is high
// RULE7 - Interrupt line low while event pending
// RULE8 - Interrupt pin open drain, never driven high
// RULE9 - Master reset low clears all, asynchronously
// RULE10 - Same port serves registers and packet FIFO
// RULE11 - Data bus released unless read in progress
package bhrp_pkg;

  // ---------------------------------------------------------------
  // Widths and map
  // ---------------------------------------------------------------
  localparam int BHRP_ADDR_W = 9;
  localparam int BHRP_DATA_W = 8;
  localparam int BHRP_REG_DEPTH = 512;
  localparam int BHRP_FIFO_DEPTH = 4;
  localparam logic [8:0] BHRP_FIFO_PORT_ADDR = 9'h1FF;
  localparam logic [8:0] BHRP_FIFO_STAT_ADDR = 9'h1FE;
  localparam logic [7:0] BHRP_REG_RESET = 8'h00;
  localparam logic [7:0] BHRP_BUS_IDLE = 8'hFF;

  // ---------------------------------------------------------------
  // FIFO status byte fields
  // ---------------------------------------------------------------
  localparam int BHRP_STAT_RX_EMPTY_BIT = 0;
  localparam int BHRP_STAT_TX_FULL_BIT = 1;
  localparam int BHRP_STAT_IRQ_BIT = 2;

  // ---------------------------------------------------------------
  // Host cycle timing, in CLK_IN cycles
  // ---------------------------------------------------------------
  localparam int BHRP_SETUP_CYCLES = 2;
  localparam int BHRP_STROBE_CYCLES = 8;
  localparam int BHRP_HOLD_CYCLES = 2;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef struct packed {
    logic cs_n;
    logic rd_n;
    logic wr_n;
    logic [8:0] addr;
    logic [7:0] data;
  } bhrp_pins_t;

  localparam bhrp_pins_t BHRP_PINS_IDLE = '{cs_n: 1'b1, rd_n: 1'b1,
    wr_n: 1'b1, addr: 9'h000, data: 8'h00};

  typedef enum logic [1:0] {
    BHRP_IDLE,
    BHRP_SETUP,
    BHRP_STROBE,
    BHRP_HOLD
  } bhrp_host_state_t;

endpackage : bhrp_pkg

// File: test/bhrp_chk.sv
// Pin checker for the byte host port, host end facing device end.
// Assumes one clock; inputs are the bhrp_if signals of the main bus.
`timescale 1ns/1ns
module bhrp_chk (
  // Clock, resets and the pending event input
  input wire logic CLK_IN,
  input wire logic RESET_IN,
  input wire logic MASTER_RESET_N_IN,
  input wire logic IRQ_PENDING_IN,
  // Bus pins and enables
  input wire logic [8:0] host_addr_lines,
  input wire logic host_select_n,
  input wire logic host_read_strobe_n,
  input wire logic host_write_strobe_n,
  input wire logic host_data_oe,
  input wire logic dev_data_oe,
  input wire logic irq_oe,
  input wire logic [7:0] host_data_lines
);
  logic rd_req;

  // Read request at the pins, write strobe high
  assign rd_req = !host_select_n && !host_read_strobe_n && host_write_strobe_n;

  // --------------------
  // Pin rules
  // --------------------
  // Either reset silences every check
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (RESET_IN || !MASTER_RESET_N_IN);

  a_read_drives_bus: assert property (rd_req[*4] |=> dev_data_oe)
    else $error("device silent during read");
  a_oe_needs_read: assert property (dev_data_oe |-> $past(rd_req, 3))
    else $error("device drives bus without read");
  a_write_no_drive: assert property (
    (!host_select_n && !host_write_strobe_n)[*4] |-> !dev_data_oe)
    else $error("device drives bus during write");
  a_bus_one_driver: assert property (!(dev_data_oe && host_data_oe))
    else $error("both ends drive data bus");
  a_idle_released: assert property (
    host_select_n[*4] |-> !dev_data_oe)
    else $error("bus driven while unselected");
  a_irq_follows: assert property (
    !$past(RESET_IN) && $past(MASTER_RESET_N_IN) |->
    irq_oe == $past(IRQ_PENDING_IN))
    else $error("interrupt pull does not follow event");
  a_strobe_width: assert property (
    $fell(host_write_strobe_n) |->
    !host_write_strobe_n[*8] ##1 host_write_strobe_n)
    else $error("write strobe width wrong");
  a_write_held: assert property (
    !host_write_strobe_n && !$fell(host_write_strobe_n) |->
    $stable(host_addr_lines) && $stable(host_data_lines) && !host_select_n)
    else $error("address or data moved in write");
  a_select_first: assert property (
    $fell(host_read_strobe_n) |-> !$past(host_select_n))
    else $error("read strobe before select");

  // Main scenarios reached
  c_read: cover property (rd_req[*4] ##1 dev_data_oe);
  c_write: cover property ($fell(host_write_strobe_n));
  c_irq: cover property ($rose(irq_oe));
endmodule : bhrp_chk

// File: test/testbench.sv
// Bench: host end and device end on one bus, a second device on pins
// that the bench drives itself to break host rules on purpose.
`timescale 1ns/1ns
module testbench;
  import bhrp_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic mrst_n = 1'b1;
  logic req_valid = 1'b0, req_write = 1'b0, req_ready, rsp_valid, irq_host;
  logic [8:0] req_addr = 9'h000, core_addr = 9'h000;
  logic [7:0] req_data = 8'h00, rsp_data, core_data, core_data_b;
  logic [7:0] rsp_data_c, core_data_c;
  logic irq_pend = 1'b0, tx_ready = 1'b0, tx_valid, rx_valid = 1'b0, rx_ready;
  logic [7:0] rx_data = 8'h00, tx_data;
  int n_errors = 0;
  int n_compared = 0;

  // --------------------
  // Clock, buses, ends
  // --------------------
  // Free running 25 MHz clock
  always #20 clk = ~clk;

  bhrp_if bus ();
  bhrp_if bus2 ();
  bhrp_if bus3 ();

  bhrp_host_end i_bhrp_host_end (.CLK_IN(clk), .RESET_IN(rst),
    .HOST_PORT(bus.host), .REQ_VALID_IN(req_valid), .REQ_WRITE_IN(req_write),
    .REQ_ADDR_IN(req_addr), .REQ_DATA_IN(req_data), .REQ_READY_OUT(req_ready),
    .RSP_VALID_OUT(rsp_valid), .RSP_DATA_OUT(rsp_data), .IRQ_OUT(irq_host));

  bhrp_device_end i_bhrp_device_end (.CLK_IN(clk), .RESET_IN(rst),
    .MASTER_RESET_N_IN(mrst_n), .HOST_PORT(bus.device),
    .IRQ_PENDING_IN(irq_pend), .LINK_TX_DATA_OUT(tx_data),
    .LINK_TX_VALID_OUT(tx_valid), .LINK_TX_READY_IN(tx_ready),
    .LINK_RX_DATA_IN(rx_data), .LINK_RX_VALID_IN(rx_valid),
    .LINK_RX_READY_OUT(rx_ready), .CORE_ADDR_IN(core_addr),
    .CORE_DATA_OUT(core_data));

  // Second device: link side tied off, only its pins and core view matter here
  bhrp_device_end i_bhrp_device_end_b (.CLK_IN(clk), .RESET_IN(rst),
    .MASTER_RESET_N_IN(mrst_n), .HOST_PORT(bus2.device),
    .IRQ_PENDING_IN(1'b0), .LINK_TX_DATA_OUT(), .LINK_TX_VALID_OUT(),
    .LINK_TX_READY_IN(1'b0), .LINK_RX_DATA_IN(8'h00), .LINK_RX_VALID_IN(1'b0),
    .LINK_RX_READY_OUT(), .CORE_ADDR_IN(core_addr),
    .CORE_DATA_OUT(core_data_b));

  // Combined read/write host and its device, fed the same requests
  bhrp_host_end #(.COMBINED_RW(1'b1)) i_bhrp_host_end_c (.CLK_IN(clk),
    .RESET_IN(rst), .HOST_PORT(bus3.host), .REQ_VALID_IN(req_valid),
    .REQ_WRITE_IN(req_write), .REQ_ADDR_IN(req_addr),
    .REQ_DATA_IN(req_data), .REQ_READY_OUT(), .RSP_VALID_OUT(),
    .RSP_DATA_OUT(rsp_data_c), .IRQ_OUT());

  bhrp_device_end i_bhrp_device_end_c (.CLK_IN(clk), .RESET_IN(rst),
    .MASTER_RESET_N_IN(mrst_n), .HOST_PORT(bus3.device),
    .IRQ_PENDING_IN(1'b0), .LINK_TX_DATA_OUT(), .LINK_TX_VALID_OUT(),
    .LINK_TX_READY_IN(1'b0), .LINK_RX_DATA_IN(8'h00), .LINK_RX_VALID_IN(1'b0),
    .LINK_RX_READY_OUT(), .CORE_ADDR_IN(core_addr),
    .CORE_DATA_OUT(core_data_c));

  bhrp_chk i_bhrp_chk (.CLK_IN(clk), .RESET_IN(rst),
    .MASTER_RESET_N_IN(mrst_n), .IRQ_PENDING_IN(irq_pend),
    .host_addr_lines(bus.host_addr_lines), .host_select_n(bus.host_select_n),
    .host_read_strobe_n(bus.host_read_strobe_n),
    .host_write_strobe_n(bus.host_write_strobe_n),
    .host_data_oe(bus.host_data_oe), .dev_data_oe(bus.dev_data_oe),
    .irq_oe(bus.irq_oe), .host_data_lines(bus.host_data_lines));

  // --------------------
  // Shared tasks
  // --------------------
  // Byte compare, case equality so unknowns fail
  task automatic chk8(input string nm, input logic [7:0] e,
                      input logic [7:0] g);
    n_compared++;
    if (g !== e) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask : chk8

  // Single bit compare
  task automatic chk1(input string nm, input logic e, input logic g);
    chk8(nm, {7'h00, e}, {7'h00, g});
  endtask : chk1

  // Request held until taken, then wait for the end's ready again
  task automatic host_op(input logic we, input logic [8:0] a,
                         input logic [7:0] d, output logic [7:0] q);
    int n;
    // Unknown until an answer arrives, so a lost answer fails the compare
    q = 8'hXX;
    req_valid <= 1'b1;
    req_write <= we;
    req_addr <= a;
    req_data <= d;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (req_ready !== 1'b1 && n < 50);
    req_valid <= 1'b0;
    n = 0;
    do begin
      @(posedge clk);
      n++;
      if (rsp_valid === 1'b1) q = rsp_data;
    end while (req_ready !== 1'b1 && n < 50);
    chk1("host ready", 1'b1, req_ready);
  endtask : host_op

  // Core view of both register files
  task automatic core_peek(input logic [8:0] a, output logic [7:0] q,
                           output logic [7:0] qb);
    core_addr <= a;
    repeat (3) @(posedge clk);
    q = core_data;
    qb = core_data_b;
  endtask : core_peek

  // Bench plays host on the second bus; drives data only when writing
  task automatic pins(input logic cs, input logic rd, input logic wr,
                      input logic [8:0] a, input logic [7:0] d);
    bus2.host_select_n <= cs;
    bus2.host_read_strobe_n <= rd;
    bus2.host_write_strobe_n <= wr;
    bus2.host_addr_lines <= a;
    bus2.host_data_out <= d;
    bus2.host_data_oe <= !wr;
    repeat (6) @(posedge clk);
  endtask : pins

  task automatic pins_idle;
    bus2.host_select_n <= 1'b1;
    bus2.host_read_strobe_n <= 1'b1;
    bus2.host_write_strobe_n <= 1'b1;
    bus2.host_data_oe <= 1'b0;
    repeat (4) @(posedge clk);
  endtask : pins_idle

  // --------------------
  // Scenarios
  // --------------------
  task automatic t_regs;
    logic [8:0] a[3] = '{9'h000, 9'h100, 9'h1FD};
    logic [7:0] d[3] = '{8'hA5, 8'h5A, 8'h81};
    logic [7:0] q, qb;
    for (int i = 0; i < 3; i++) host_op(1'b1, a[i], d[i], q);
    for (int i = 0; i < 3; i++) begin
      host_op(1'b0, a[i], 8'h00, q);
      chk8("read back", d[i], q);
      chk8("combined read", d[i], rsp_data_c);
      core_peek(a[i], q, qb);
      chk8("core data", d[i], q);
      chk8("combined write", d[i], core_data_c);
    end
  endtask : t_regs

  task automatic t_fifo;
    logic [7:0] q;
    host_op(1'b1, 9'h1FF, 8'h3C, q);
    host_op(1'b1, 9'h1FF, 8'hC3, q);
    chk1("tx valid", 1'b1, tx_valid);
    chk8("tx head", 8'h3C, tx_data);
    tx_ready <= 1'b1;
    @(posedge clk);
    tx_ready <= 1'b0;
    @(posedge clk);
    chk8("tx next", 8'hC3, tx_data);
    tx_ready <= 1'b1;
    @(posedge clk);
    tx_ready <= 1'b0;
    rx_data <= 8'h96;
    rx_valid <= 1'b1;
    @(posedge clk);
    rx_valid <= 1'b0;
    chk1("tx drained", 1'b0, tx_valid);
    host_op(1'b0, 9'h1FE, 8'h00, q);
    chk8("status rx held", 8'h00, q);
    host_op(1'b0, 9'h1FF, 8'h00, q);
    chk8("rx byte", 8'h96, q);
    // Fill the tx side until it reports full
    for (int i = 0; i < 4; i++) host_op(1'b1, 9'h1FF, 8'(i), q);
    host_op(1'b0, 9'h1FE, 8'h00, q);
    chk8("status full", 8'h03, q);
    tx_ready <= 1'b1;
    repeat (4) @(posedge clk);
    tx_ready <= 1'b0;
  endtask : t_fifo

  task automatic t_irq;
    logic [7:0] q;
    irq_pend <= 1'b1;
    repeat (5) @(posedge clk);
    chk1("irq pin", 1'b0, bus.host_irq_n);
    chk1("irq seen", 1'b1, irq_host);
    host_op(1'b0, 9'h1FE, 8'h00, q);
    chk8("irq status", 8'h05, q);
    irq_pend <= 1'b0;
    repeat (5) @(posedge clk);
    chk1("irq pulled up", 1'b1, bus.host_irq_n);
  endtask : t_irq

  task automatic t_pins;
    logic [7:0] q, qb;
    pins(1'b1, 1'b1, 1'b0, 9'h010, 8'h3C);
    pins_idle;
    pins(1'b0, 1'b0, 1'b0, 9'h011, 8'hC3);
    chk8("bus in write", 8'hC3, bus2.host_data_lines);
    pins_idle;
    pins(1'b1, 1'b0, 1'b1, 9'h011, 8'h00);
    chk8("bus unselected", BHRP_BUS_IDLE, bus2.host_data_lines);
    pins_idle;
    pins(1'b0, 1'b0, 1'b1, 9'h011, 8'h00);
    chk8("bus read", 8'hC3, bus2.host_data_lines);
    pins_idle;
    chk8("bus released", BHRP_BUS_IDLE, bus2.host_data_lines);
    core_peek(9'h010, q, qb);
    chk8("unselected write", 8'h00, qb);
    core_peek(9'h011, q, qb);
    chk8("both strobes low", 8'hC3, qb);
  endtask : t_pins

  task automatic t_mreset;
    logic [7:0] q, qb;
    host_op(1'b1, 9'h1FF, 8'h77, q);
    // Fill the link-to-host side so its ready drops
    rx_data <= 8'h5A;
    rx_valid <= 1'b1;
    repeat (4) @(posedge clk);
    rx_valid <= 1'b0;
    core_peek(9'h100, q, qb);
    chk1("rx full", 1'b0, rx_ready);
    // Checked before the next edge, so only an async clear passes
    mrst_n <= 1'b0;
    #5;
    chk8("core in reset", 8'h00, core_data);
    chk1("tx in reset", 1'b0, tx_valid);
    chk1("rx in reset", 1'b1, rx_ready);
    @(posedge clk);
    mrst_n <= 1'b1;
    host_op(1'b0, 9'h100, 8'h00, q);
    chk8("reg after reset", 8'h00, q);
  endtask : t_mreset

  // --------------------
  // Run control
  // --------------------
  task automatic complete_run;
    $display("mismatches %0d of %0d compared", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : complete_run

  // Main sequence
  initial begin
    bus2.host_select_n = 1'b1;
    bus2.host_read_strobe_n = 1'b1;
    bus2.host_write_strobe_n = 1'b1;
    bus2.host_addr_lines = 9'h000;
    bus2.host_data_out = 8'h00;
    bus2.host_data_oe = 1'b0;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_regs();
    t_fifo();
    t_irq();
    t_pins();
    t_mreset();
    complete_run();
  end

  // Whole run needs well under a thousand host cycles
  initial begin
    repeat (5000) @(posedge clk);
    n_errors++;
    complete_run();
  end
endmodule : testbench
